// File: logic/kbr_regs.svh
// Purpose: Offsets, field positions, reset values and report constants
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by its bare name
`ifndef KBR_REGS_SVH
`define KBR_REGS_SVH
`define KBR_OFS_CTRL    12'h000
`define KBR_OFS_RPTID   12'h004
`define KBR_OFS_STATUS  12'h008
`define KBR_OFS_MASK    12'h00c
`define KBR_OFS_KEYMAP  12'h010
`define KBR_OFS_HELD    12'h014
`define KBR_CTRL_EN     0
`define KBR_ST_NEW      0
`define KBR_ST_OVF      1
`define KBR_ST_FETCH    2
`define KBR_RST_EN      1'b1
`define KBR_RST_RPTID   8'h01
`define KBR_RST_MASK    3'h0
`define KBR_CFG_ID_LOC  16'h0202
`define KBR_LEN_LO      8'h0b
`define KBR_LEN_HI      8'h00
`define KBR_MOD_HI5     5'h1c
`define KBR_BYTE_LEN0   4'h0
`define KBR_BYTE_LEN1   4'h1
`define KBR_BYTE_ID     4'h2
`define KBR_BYTE_MOD    4'h3
`define KBR_BYTE_RSV    4'h4
`define KBR_BYTE_KEY0   4'h5
`define KBR_BYTE_LAST   4'ha
`define KBR_MAX_KEYS    3'h6
`define KBR_I2C_ADDR    7'h3b
`endif

// File: logic/kbr_pkg.sv
// Purpose: Types shared by the report builder files
// Assumes: 128 matrix positions, 8-bit usage IDs
// Notes:   Constants live in kbr_regs.svh
package kbr_pkg;
   typedef struct packed {
      logic [6:0] pos;
      logic       pressed;
   } kbr_key_evt_t;
   typedef enum logic [0:0] {KB_IDLE, KB_LOOK} kbr_main_st_t;
   typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_AACK, LK_TX, LK_RACK} kbr_link_st_t;
   typedef struct packed {
      kbr_main_st_t   st;
      logic           en;
      logic [7:0]     idReg;
      logic [2:0]     status;
      logic [2:0]     mask;
      logic [7:0]     mods;
      logic [5:0][7:0] keys;
      logic [2:0]     cnt;
      logic [7:0]     rptId;
      logic [31:0]    prdata;
      logic           pslverr;
      logic           pressed;
      logic           kmWe;
      logic [6:0]     kmPos;
      logic [7:0]     kmUsage;
   } kbr_core_t;
   typedef struct packed {
      kbr_link_st_t st;
      logic [2:0]   scl;
      logic [2:0]   sda;
      logic [7:0]   sh;
      logic [3:0]   cnt;
      logic [3:0]   idx;
      logic         dr;
      logic         ack;
      logic         fetched;
   } kbr_link_t;
endpackage : kbr_pkg

// File: logic/kbr_keymap_store.sv
// Purpose: Keyboard map, matrix position to usage ID
// Assumes: Written by software over the register bus
// Notes:   One-cycle registered read
`timescale 1ns/1ps
module kbr_keymap_store import kbr_pkg::*; #(
   parameter int POSITIONS = 128
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Write port
   input  wire logic       we,
   input  wire logic [6:0] wPos,
   input  wire logic [7:0] wUsage,
   // Read port
   input  wire logic [6:0] rPos,
   output      logic [7:0] rUsage
);
   logic [7:0] mem [POSITIONS];
   // Reset clears the map, so unmapped keys read as usage zero
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < POSITIONS; i++) begin
            mem[i] <= 8'h00;
         end
         rUsage <= 8'h00;
      end else begin
         if (we) begin
            mem[wPos] <= wUsage;
         end
         rUsage <= mem[rPos];
      end
   end
endmodule : kbr_keymap_store

// File: logic/kbr_link_reader.sv
// Purpose: Read-only two-wire slave that returns the pending report
// Assumes: Link clock far slower than clock
// Notes:   Address with write direction is not acknowledged
`timescale 1ns/1ps
`include "kbr_regs.svh"
module kbr_link_reader import kbr_pkg::*; #(
   parameter logic [6:0] ADDR = `KBR_I2C_ADDR
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Pins
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output      logic       sdaOut,
   output      logic       sdaOe,
   // Report byte access
   output      logic [3:0] byteIdx,
   input  wire logic [7:0] byteData,
   output      logic       fetched
);
   kbr_link_t cur, nxt;
   logic rise, fall, start, stop;
   assign rise = cur.scl[1] & ~cur.scl[2];
   assign fall = ~cur.scl[1] & cur.scl[2];
   assign start = cur.scl[1] & cur.sda[2] & ~cur.sda[1];
   assign stop = cur.scl[1] & ~cur.sda[2] & cur.sda[1];
   always_comb begin
      nxt = cur;
      nxt.scl = {cur.scl[1:0], sclIn};
      nxt.sda = {cur.sda[1:0], sdaIn};
      nxt.fetched = 1'b0;
      if (start) begin
         nxt.st = LK_ADDR;
         nxt.cnt = 4'h0;
         nxt.dr = 1'b0;
      end else if (stop) begin
         nxt.st = LK_IDLE;
         nxt.dr = 1'b0;
      end else begin
         case (cur.st)
            LK_ADDR: begin
               if (rise) begin
                  nxt.sh = {cur.sh[6:0], cur.sda[1]};
                  nxt.cnt = cur.cnt + 4'h1;
               end else if (fall && cur.cnt == 4'h8) begin
                  // Only a read as first transaction is answered
                  if (cur.sh[7:1] == ADDR && cur.sh[0]) begin
                     nxt.st = LK_AACK;
                     nxt.dr = 1'b1;
                     nxt.idx = 4'h0;
                  end else begin
                     nxt.st = LK_IDLE;
                  end
               end
            end
            LK_AACK, LK_RACK: begin
               if (rise && cur.st == LK_RACK) begin
                  nxt.ack = ~cur.sda[1];
                  if (~cur.sda[1]) begin
                     nxt.idx = cur.idx + 4'h1;
                  end
               end else if (fall) begin
                  if (cur.st == LK_AACK || cur.ack) begin
                     nxt.st = LK_TX;
                     nxt.sh = byteData;
                     nxt.dr = ~byteData[7];
                     nxt.cnt = 4'h0;
                  end else begin
                     nxt.st = LK_IDLE;
                     nxt.fetched = 1'b1;
                  end
               end
            end
            LK_TX: begin
               if (fall) begin
                  if (cur.cnt == 4'h7) begin
                     nxt.st = LK_RACK;
                     nxt.dr = 1'b0;
                  end else begin
                     nxt.sh = {cur.sh[6:0], 1'b0};
                     nxt.dr = ~cur.sh[6];
                     nxt.cnt = cur.cnt + 4'h1;
                  end
               end
            end
            default: begin
               nxt.st = LK_IDLE;
               nxt.dr = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         cur <= '{st: LK_IDLE, scl: 3'h7, sda: 3'h7, default: '0};
      end else begin
         cur <= nxt;
      end
   end
   assign sdaOut = 1'b0;
   assign sdaOe = cur.dr;
   assign byteIdx = cur.idx;
   assign fetched = cur.fetched;

   sequence s_addr_read;
      cur.st == LK_ADDR && fall && !start && !stop && cur.cnt == 4'h8 && cur.sh[7:1] == ADDR;
   endsequence
   a_read_acked: assert property (@(posedge clock) disable iff (rst)
      s_addr_read and cur.sh[0] |=> cur.st == LK_AACK && sdaOe && byteIdx == 4'h0)
      else $error("read address not acknowledged");
   a_write_ignored: assert property (@(posedge clock) disable iff (rst)
      s_addr_read and !cur.sh[0] |=> cur.st == LK_IDLE && !sdaOe)
      else $error("write address answered");
endmodule : kbr_link_reader

// File: logic/kbr_report_builder.sv
// Purpose: Keyboard input report builder with register bus and report link
// Assumes: Key events arrive from debounced scan logic on the same clock
// Notes:   Summary of operation follows
// Summary of operation
// - At most six ordinary keys and eight modifiers are held in one report.
// - Usage IDs e0 to e7 are modifiers, left control up to right system key.
// - Byte 3 is the modifier bitmap, bit 0 left control to bit 7 right system key.
// - Report bytes are length, length, ID, modifiers, reserved, then six key slots.
// - The length field always reads 11, low byte first, high byte zero.
// - Every press and every release that changes the held set builds a new report.
// - With nothing held the report is zero apart from length and ID.
// - Modifier-only changes also build reports, with key slots unchanged.
// - Usage IDs come from a writable keyboard map indexed by matrix position.
// - The ID byte carries the report ID from the RPTID register, copied when a report is built.
// - A bare read on the link returns the pending report.
`timescale 1ns/1ps
`include "kbr_regs.svh"
module kbr_report_builder import kbr_pkg::*; #(
   parameter logic [6:0] LINK_ADDR = `KBR_I2C_ADDR,
   parameter int         POSITIONS = 128
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output      logic [31:0]  prdata,
   output      logic         pready,
   output      logic         pslverr,
   // Key events
   input  wire kbr_key_evt_t keyEvt,
   input  wire logic         keyValid,
   output      logic         keyReady,
   // Report link pins
   input  wire logic         sclIn,
   input  wire logic         sdaIn,
   output      logic         sdaOut,
   output      logic         sdaOe,
   // Interrupt
   output      logic         irq
);
   kbr_core_t  cur, nxt;
   logic [7:0] usage;
   logic [3:0] linkIdx;
   logic [7:0] linkByte;
   logic       fetched;
   logic       changed;
   logic       overflow;
   logic       setup;
   logic       access;

   function automatic logic isModifier(input logic [7:0] u);
      return u[7:3] == `KBR_MOD_HI5;
   endfunction : isModifier

   function automatic logic [7:0] reportByte(input logic [3:0] idx, input kbr_core_t s);
      logic [7:0] b;
      b = 8'h00;
      // Byte layout of the standard report
      case (idx)
         `KBR_BYTE_LEN0: b = `KBR_LEN_LO;
         `KBR_BYTE_LEN1: b = `KBR_LEN_HI;
         `KBR_BYTE_ID:   b = s.rptId;
         `KBR_BYTE_MOD:  b = s.mods;
         `KBR_BYTE_RSV:  b = 8'h00;
         default: begin
            if (idx >= `KBR_BYTE_KEY0 && idx <= `KBR_BYTE_LAST) begin
               b = s.keys[3'(idx - `KBR_BYTE_KEY0)];
            end
         end
      endcase
      return b;
   endfunction : reportByte

   kbr_keymap_store #(
      .POSITIONS (POSITIONS)
   ) u_keymap (
      .clock  (clock),
      .rst    (rst),
      .we     (cur.kmWe),
      .wPos   (cur.kmPos),
      .wUsage (cur.kmUsage),
      .rPos   (keyEvt.pos),
      .rUsage (usage)
   );

   kbr_link_reader #(
      .ADDR (LINK_ADDR)
   ) u_link (
      .clock    (clock),
      .rst      (rst),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sdaOut   (sdaOut),
      .sdaOe    (sdaOe),
      .byteIdx  (linkIdx),
      .byteData (linkByte),
      .fetched  (fetched)
   );

   // A report replaced during a link read may mix old and new bytes
   assign linkByte = reportByte(linkIdx, cur);
   assign setup = psel & ~penable;
   assign access = psel & penable;

   always_comb begin
      logic [2:0] setSt;
      logic [2:0] clrSt;
      logic       found;
      logic [2:0] hit;
      nxt = cur;
      setSt = 3'h0;
      clrSt = 3'h0;
      found = 1'b0;
      hit = 3'h0;
      changed = 1'b0;
      overflow = 1'b0;
      nxt.kmWe = 1'b0;
      case (cur.st)
         KB_IDLE: begin
            if (keyValid) begin
               // Map lookup starts now, answer is ready next cycle
               nxt.st = KB_LOOK;
               nxt.pressed = keyEvt.pressed;
            end
         end
         KB_LOOK: begin
            nxt.st = KB_IDLE;
            for (int i = 0; i < 6; i++) begin
               if (!found && 3'(i) < cur.cnt && cur.keys[i] == usage) begin
                  found = 1'b1;
                  hit = 3'(i);
               end
            end
            // Usage zero marks an unmapped position and is dropped
            if (!cur.en || usage == 8'h00) begin
               changed = 1'b0;
            end else if (isModifier(usage)) begin
               // Low three bits pick the bitmap position
               changed = cur.mods[usage[2:0]] != cur.pressed;
               nxt.mods[usage[2:0]] = cur.pressed;
            end else if (cur.pressed) begin
               if (!found && cur.cnt == `KBR_MAX_KEYS) begin
                  overflow = 1'b1;
               end else if (!found) begin
                  changed = 1'b1;
                  nxt.keys[cur.cnt] = usage;
                  nxt.cnt = cur.cnt + 3'h1;
               end
            end else if (found) begin
               // Close the gap so slots stay in press order
               changed = 1'b1;
               for (int j = 0; j < 5; j++) begin
                  if (3'(j) >= hit) begin
                     nxt.keys[j] = cur.keys[j + 1];
                  end
               end
               nxt.keys[5] = 8'h00;
               nxt.cnt = cur.cnt - 3'h1;
            end
            if (changed) begin
               nxt.rptId = cur.idReg;
               setSt[`KBR_ST_NEW] = 1'b1;
            end
            setSt[`KBR_ST_OVF] = overflow;
         end
         default: begin
            nxt.st = KB_IDLE;
         end
      endcase
      setSt[`KBR_ST_FETCH] = fetched;
      // Read data and error are prepared in the setup phase
      if (setup) begin
         nxt.prdata = 32'h0000_0000;
         nxt.pslverr = 1'b0;
         case (paddr)
            `KBR_OFS_CTRL:   nxt.prdata = {31'h0, cur.en};
            `KBR_OFS_RPTID:  nxt.prdata = {24'h0, cur.idReg};
            `KBR_OFS_STATUS: nxt.prdata = {29'h0, cur.status};
            `KBR_OFS_MASK:   nxt.prdata = {29'h0, cur.mask};
            `KBR_OFS_KEYMAP: nxt.prdata = 32'h0000_0000;
            `KBR_OFS_HELD:   nxt.prdata = {21'h0, cur.cnt, cur.mods};
            default:         nxt.pslverr = 1'b1;
         endcase
      end
      if (access && pwrite) begin
         case (paddr)
            `KBR_OFS_CTRL:   nxt.en = pwdata[`KBR_CTRL_EN];
            `KBR_OFS_RPTID:  nxt.idReg = pwdata[7:0];
            `KBR_OFS_STATUS: clrSt = pwdata[2:0];
            `KBR_OFS_MASK:   nxt.mask = pwdata[2:0];
            `KBR_OFS_KEYMAP: begin
               nxt.kmWe = 1'b1;
               nxt.kmPos = pwdata[14:8];
               nxt.kmUsage = pwdata[7:0];
            end
            default: begin
               nxt.kmWe = 1'b0;
            end
         endcase
      end
      // An event in the clearing cycle survives
      nxt.status = (cur.status & ~clrSt) | setSt;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur <= '{st: KB_IDLE, en: `KBR_RST_EN, idReg: `KBR_RST_RPTID,
                  rptId: `KBR_RST_RPTID, mask: `KBR_RST_MASK, default: '0};
      end else begin
         cur <= nxt;
      end
   end

   assign keyReady = cur.st == KB_IDLE;
   assign prdata = cur.prdata;
   assign pslverr = cur.pslverr;
   assign pready = 1'b1;
   assign irq = |(cur.status & cur.mask);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic found_any;
   always_comb begin
      found_any = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (3'(i) < cur.cnt && cur.keys[i] == usage) begin
            found_any = 1'b1;
         end
      end
   end

   sequence s_look;
      cur.st == KB_LOOK && cur.en && usage != 8'h00;
   endsequence
   sequence s_key_press;
      s_look ##0 cur.pressed && !isModifier(usage) && cur.cnt < `KBR_MAX_KEYS && !found_any;
   endsequence

   a_len_fixed: assert property (
      reportByte(`KBR_BYTE_LEN0, cur) == 8'h0b && reportByte(`KBR_BYTE_LEN1, cur) == 8'h00)
      else $error("length field not 11");
   a_six_max: assert property (cur.cnt <= 3'h6)
      else $error("more than six keys held");
   a_unused_zero: assert property (
      cur.cnt == 3'h0 |-> cur.keys == '0 && reportByte(`KBR_BYTE_RSV, cur) == 8'h00)
      else $error("empty report not zero");
   a_slot_order: assert property (s_key_press |=>
      cur.keys[$past(cur.cnt)] == $past(usage) && cur.cnt == $past(cur.cnt) + 3'h1)
      else $error("key not placed in next slot");
   a_seventh_drop: assert property (
      s_look ##0 cur.pressed && !isModifier(usage) && cur.cnt == 3'h6 && !found_any
      |=> $stable(cur.keys) && cur.status[`KBR_ST_OVF])
      else $error("seventh key not dropped");
   a_mod_bitmap: assert property (
      s_look ##0 isModifier(usage) |=> cur.mods[$past(usage[2:0])] == $past(cur.pressed)
      && reportByte(`KBR_BYTE_MOD, cur) == cur.mods)
      else $error("modifier bit wrong");
   a_change_flag: assert property (
      cur.st == KB_LOOK && changed |=> cur.status[`KBR_ST_NEW] ##1 cur.st == KB_IDLE
      || cur.st == KB_LOOK)
      else $error("change did not flag report");
   a_id_fill: assert property (
      cur.st == KB_LOOK && changed |=> reportByte(`KBR_BYTE_ID, cur) == $past(cur.idReg))
      else $error("report ID not filled");
   a_mod_only: assert property (
      s_look ##0 isModifier(usage) |=> $stable(cur.keys) && $stable(cur.cnt))
      else $error("modifier touched key slots");
endmodule : kbr_report_builder

// File: bench/kbr_link_host.sv
// Purpose: Two-wire host model that fetches input reports
// Assumes: Data line pulled up, link clock idles high between frames
// Notes:   Quarter period 40 ns gives the 160 ns link clock
`timescale 1ns/1ps
module kbr_link_host #(
   parameter int Q = 40
) (
   // Pins
   output logic      scl,
   output logic      pull,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // One bit slot; sample on the rise, device moves after the fall
   task automatic bit9(input logic b, output logic s);
      pull = !b;
      #Q scl = 1'b1;
      s = sda;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask : bit9
   // Bare read as first transfer, no address write ahead
   task automatic fetch(input logic [7:0] a, input int n, output logic ack,
                        output logic [7:0] d [11]);
      logic s;
      pull = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
      for (int i = 7; i >= 0; i--) begin
         bit9(a[i], s);
      end
      bit9(1'b1, s);
      ack = !s;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 8; i++) begin
            bit9(1'b1, s);
            d[k] = {d[k][6:0], s};
         end
         // Nack on the last byte ends the read
         bit9(k == n - 1, s);
      end
      pull = 1'b1;
      #Q scl = 1'b1;
      #Q pull = 1'b0;
      #(2*Q);
   endtask : fetch
endmodule : kbr_link_host

// File: bench/testbench.sv
// Purpose: Self-checking bench for the keyboard report builder
// Assumes: Zero-wait register bus, link host model on the pins
// Notes:   Expected reports come from a small held-key model
`timescale 1ns/1ps
`include "kbr_regs.svh"
module testbench import kbr_pkg::*; ;
   logic         clock;
   logic         rst;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   kbr_key_evt_t keyEvt;
   logic         keyValid;
   logic         keyReady;
   logic         scl;
   logic         hostPull;
   logic         sdaOut;
   logic         sdaOe;
   logic         irq;
   wire          sdaLine = !(sdaOe && !sdaOut) && !hostPull;
   int           errorCnt;
   int           checksDone;
   int           perm [16];
   logic [7:0]   map [128];
   logic [7:0]   held [$];
   logic [7:0]   mods;
   logic [7:0]   rptId;
   logic [7:0]   rpt [11];
   logic [31:0]  rd;
   logic         err;
   logic         ack;
   always #4 clock = ~clock;
   kbr_report_builder dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .keyEvt(keyEvt), .keyValid(keyValid), .keyReady(keyReady),
      .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
   kbr_link_host host (.scl(scl), .pull(hostPull), .sda(sdaLine));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Idle cycle after each transfer keeps psel edges apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      logic r;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         r = pready;
         rd = prdata;
         err = pslverr;
      end while (r !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic key(input logic [6:0] p, input logic pr);
      logic r;
      keyEvt <= '{pos: p, pressed: pr};
      keyValid <= 1'b1;
      do begin
         @(posedge clock);
         r = keyReady;
      end while (r !== 1'b1);
      keyValid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : key
   task automatic press(input logic [6:0] p, input logic pr);
      int ix [$];
      key(p, pr);
      ix = held.find_first_index(x) with (x == map[p]);
      if (map[p] >= 8'he0 && map[p] <= 8'he7) mods[map[p][2:0]] = pr;
      else if (pr && held.size() < 6) held.push_back(map[p]);
      else if (!pr && ix.size() > 0) held.delete(ix[0]);
   endtask : press
   function automatic logic [7:0] exp_byte(int i);
      case (i)
         0: return 8'h0b;
         1: return 8'h00;
         2: return rptId;
         3: return mods;
         4: return 8'h00;
         default: return (i - 5 < held.size()) ? held[i - 5] : 8'h00;
      endcase
   endfunction : exp_byte
   task automatic report();
      host.fetch({`KBR_I2C_ADDR, 1'b1}, 11, ack, rpt);
      @(posedge clock);
      chk("link ack", 1'b1, ack);
      for (int i = 0; i < 11; i++) begin
         chk($sformatf("byte %0d", i), exp_byte(i), rpt[i]);
      end
      apb(1'b0, `KBR_OFS_HELD, 32'h0);
      chk("held", {21'h0, 3'(held.size()), mods}, rd);
      apb(1'b0, `KBR_OFS_STATUS, 32'h0);
      chk("fetch flag", 1'b1, rd[`KBR_ST_FETCH]);
      apb(1'b1, `KBR_OFS_STATUS, 32'h7);
   endtask : report
   task automatic summarize();
      $display("checks %0d mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (100000) @(posedge clock);
      errorCnt++;
      $display("BAD watchdog expected end seen hang");
      summarize();
   end
   initial begin
      int j;
      int t;
      clock = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, keyValid} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      keyEvt = '0;
      {errorCnt, checksDone} = 0;
      mods = 8'h00;
      void'($urandom(86));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, `KBR_OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h1, rd);
      apb(1'b0, `KBR_OFS_RPTID, 32'h0);
      chk("id reset", 32'h1, rd);
      apb(1'b0, `KBR_OFS_STATUS, 32'h0);
      chk("status reset", 32'h0, rd);
      apb(1'b1, 12'h018, 32'h5);
      chk("unmapped err", 1'b1, err);
      $display("test reset done");
      // Positions 0 to 15 mapped at random, 100 to 107 to modifiers; usage is never fixed in logic
      for (int p = 0; p < 128; p++) begin
         map[p] = (p < 16) ? 8'h04 + 8'(p * 8) + 8'($urandom % 8) : 8'h00;
         if (p >= 100 && p < 108) map[p] = 8'he0 + 8'(p - 100);
         if (map[p] != 8'h00) apb(1'b1, `KBR_OFS_KEYMAP, {17'h0, 7'(p), map[p]});
         if (p < 16) perm[p] = p;
      end
      for (int i = 15; i > 0; i--) begin
         j = int'($urandom % (i + 1));
         t = perm[i];
         perm[i] = perm[j];
         perm[j] = t;
      end
      rptId = 8'($urandom % 255 + 1);
      apb(1'b1, `KBR_OFS_RPTID, {24'h0, rptId});
      apb(1'b1, `KBR_OFS_MASK, 32'h2);
      for (int i = 0; i < 7; i++) begin
         press(7'(perm[i]), 1'b1);
         chk("irq on drop", i == 6, irq);
      end
      report();
      key(7'd127, 1'b1);
      key(7'(perm[0]), 1'b1);
      apb(1'b0, `KBR_OFS_STATUS, 32'h0);
      chk("refused events", 32'h0, rd);
      press(7'(perm[2]), 1'b0);
      report();
      press(7'(perm[6]), 1'b1);
      report();
      $display("test six keys done");
      for (int i = 0; i < 7; i++) begin
         if (i == 2) continue;
         press(7'(perm[i]), 1'b0);
         apb(1'b0, `KBR_OFS_STATUS, 32'h0);
         chk("release report", 1'b1, rd[`KBR_ST_NEW]);
         apb(1'b1, `KBR_OFS_STATUS, 32'h1);
      end
      report();
      for (int i = 0; i < 6; i++) begin
         j = int'($urandom % 16);
         press(7'(j), !(map[j] inside {held}));
         report();
      end
      for (int i = 0; i < 16; i++) begin
         if (map[i] inside {held}) press(7'(i), 1'b0);
      end
      $display("test random churn done");
      for (int m = 0; m < 8; m++) begin
         press(7'(100 + m), 1'b1);
         report();
      end
      for (int m = 0; m < 8; m++) begin
         press(7'(100 + m), 1'b0);
      end
      report();
      host.fetch({`KBR_I2C_ADDR, 1'b0}, 0, ack, rpt);
      @(posedge clock);
      chk("write dir ack", 1'b0, ack);
      $display("test modifiers done");
      summarize();
   end
endmodule : testbench
